// >>> pio_pkg.sv
// Shared constants and types for the peripheral I/O bus control block
package pio_pkg;

  // ****************
  // Timing
  // ****************
  localparam int CLK_PS = 4000; // 250 MHz core clock period in ps
  localparam int SETUP_NS = 20; // Address and select setup before a strobe
  localparam int STROBE_NS = 125; // Least read/write strobe width
  localparam int REF_MHZ = 16; // PC-type reference clock
  localparam int REF_HALF_PS = 1000000 / (2 * REF_MHZ);
  // Least times round up, the clock half period rounds down
  localparam logic [7:0] SETUP_CYC = 8'((SETUP_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam logic [7:0] STROBE_CYC = 8'((STROBE_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam logic [7:0] REF_HALF_CYC = 8'(REF_HALF_PS / CLK_PS);

  // ****************
  // Access kinds and cycle states
  // ****************
  typedef enum logic [1:0] {
    KIND_SIMPLE = 2'h0,
    KIND_MODULE = 2'h1,
    KIND_PC = 2'h2,
    KIND_ROM = 2'h3
  } pio_kind_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SETUP = 3'h1,
    ST_HSHAKE = 3'h2,
    ST_STROBE = 3'h3,
    ST_LATCH = 3'h4,
    ST_HOLD = 3'h5
  } pio_state_e;

  // ****************
  // Chip select vector layout and decode pages
  // ****************
  localparam int SEL_W = 7;
  localparam int SEL_SIMPLE_A = 0;
  localparam int SEL_SIMPLE_B = 1;
  localparam int SEL_MODULE = 2;
  localparam int SEL_EXT_PC = 3;
  localparam int SEL_COMBO = 4;
  localparam int SEL_AREA0 = 5;
  localparam int SEL_AREA1 = 6;
  localparam logic [3:0] PAGE_COMBO = 4'h3;
  localparam logic [3:0] PAGE_AREA0 = 4'h4;
  localparam logic [3:0] PAGE_AREA1 = 4'h5;

endpackage

// >>> pio_decode.sv
// Chip select decoder for the peripheral I/O bus control block
`timescale 1ns/1ps
module pio_decode (
  // Access description
  input wire logic [1:0] kind_i,
  input wire logic [3:0] page_i,
  input wire logic dma_i,
  // Board strap
  input wire logic decode_option_strap_i,
  // One-hot select vector
  output logic [pio_pkg::SEL_W-1:0] sel_o
);

  // Upper page test; the strap widens it from one bit to two
  function automatic logic upper_page(input logic [3:0] page, input logic strap);
    upper_page = strap ? (page[3:2] == 2'h3) : page[3];
  endfunction

  // Select decode per access kind
  always_comb begin
    sel_o = '0;
    case (pio_pkg::pio_kind_e'(kind_i))
      pio_pkg::KIND_SIMPLE: begin
        if (upper_page(page_i, decode_option_strap_i)) begin
          sel_o[pio_pkg::SEL_SIMPLE_B] = 1'b1;
        end else begin
          sel_o[pio_pkg::SEL_SIMPLE_A] = 1'b1;
        end
      end
      pio_pkg::KIND_MODULE: begin
        if (decode_option_strap_i && page_i[3]) begin
          sel_o[pio_pkg::SEL_EXT_PC] = 1'b1;
        end else begin
          sel_o[pio_pkg::SEL_MODULE] = 1'b1;
        end
      end
      pio_pkg::KIND_PC: begin
        if (dma_i || page_i == pio_pkg::PAGE_COMBO) begin
          sel_o[pio_pkg::SEL_COMBO] = 1'b1;
        end else if (page_i == pio_pkg::PAGE_AREA0) begin
          sel_o[pio_pkg::SEL_AREA0] = 1'b1;
        end else if (page_i == pio_pkg::PAGE_AREA1) begin
          sel_o[pio_pkg::SEL_AREA1] = 1'b1;
        end else if (decode_option_strap_i && !page_i[3]) begin
          sel_o[pio_pkg::SEL_SIMPLE_B] = 1'b1;
        end else begin
          sel_o[pio_pkg::SEL_EXT_PC] = 1'b1;
        end
      end
      default: begin
        sel_o = '0;
      end
    endcase
  end

endmodule // pio_decode

// >>> pio_ctrl.sv
// Peripheral I/O bus cycle controller: strobes, selects, handshake, wide path
// Operation
// - PC-type cycles stretch while the wait input is held low.
// - Module-type cycles raise a request and continue only after grant.
// - Module-type reads capture the data port when latch-in goes low.
// - Drive a low latch strobe for the external upper-half latch.
// - Enable the upper transceiver low during the upper phase of 32-bit reads.
// - Enable the upper transceiver low during the lower phase of 32-bit writes.
// - Halfword select input picks upper or lower write halfword.
// - XIP hold input keeps the upper halfword while lower is read.
// - First simple select is low for simple I/O accesses outside the upper pages.
// - Strap input alters decode of second simple, module and extended selects.
// - Dedicated low select for the combo peripheral chip.
// - Combined select and DMA acknowledge to combo chip for pseudo-DMA.
// - Terminal count high with the DMA acknowledge ends a pseudo-DMA.
// - Two more low selects, one per area of PC-type space.
// - Output a latched copy of the byte/word size indication.
// - Direction output is high for reads and low for writes.
// - Read strobe pulses for simple, PC and ROM reads, not module reads.
// - Write strobe acts on ROM writes only when ROM writes are enabled.
// - Supply a reference clock output for PC-type cycles: 16 MHz nominal, 7-cycle half period, about 17.9 MHz.
`timescale 1ns/1ps
module pio_ctrl (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // Internal request side
  input wire logic req_i,
  input wire logic [1:0] req_kind_i,
  input wire logic req_write_i,
  input wire logic req_wide_i,
  input wire logic [15:0] req_addr_i,
  input wire logic [31:0] req_wdata_i,
  input wire logic req_dma_i,
  input wire logic req_dma_last_i,
  input wire logic byte_not_word_i,
  input wire logic rom_write_enable_i,
  output logic busy_o,
  output logic done_o,
  output logic [31:0] rdata_o,
  // Data port
  input wire logic [15:0] io_data_port_i,
  output logic [15:0] io_data_port_o,
  output logic io_data_port_oe_n_o,
  // Handshake and sampled inputs
  input wire logic ready_i,
  input wire logic module_io_grant_n_i,
  input wire logic read_latch_in_n_i,
  input wire logic xip_halfword_select_n_i,
  input wire logic xip_upper_hold_n_i,
  input wire logic decode_option_strap_i,
  // Strobes and wide-path control
  output logic module_io_request_n_o,
  output logic upper_latch_out_n_o,
  output logic upper_read_enable_n_o,
  output logic upper_write_enable_n_o,
  output logic io_read_n_o,
  output logic io_write_n_o,
  output logic io_read_not_write_o,
  output logic byte_not_word_o,
  output logic ref16_clk_o,
  // Chip selects
  output logic simple_select_a_n_o,
  output logic simple_select_b_n_o,
  output logic module_select_n_o,
  output logic extended_pc_select_n_o,
  output logic combo_select_n_o,
  output logic combo_dma_ack_n_o,
  output logic terminal_count_o,
  output logic pc_area0_select_n_o,
  output logic pc_area1_select_n_o
);

  // ****************
  // State
  // ****************
  typedef struct packed {
    pio_pkg::pio_state_e st;
    logic [7:0] cnt;
    logic [7:0] ref_cnt;
    logic ref_clk;
    logic [1:0] kind;
    logic write;
    logic wide;
    logic dma;
    logic last;
    logic rom_we;
    logic up;
    logic [pio_pkg::SEL_W-1:0] sel;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [15:0] dout;
    logic done;
    logic bnw;
    logic oe_n;
    logic rnw;
    logic rd_n;
    logic wr_n;
    logic blo_n;
    logic rbe_n;
    logic wbe_n;
    logic rq_n;
    logic [pio_pkg::SEL_W-1:0] cs_n;
    logic cdack_n;
    logic tc;
  } pio_core_t;

  pio_core_t q_ff;
  pio_core_t nxt_q;
  logic [pio_pkg::SEL_W-1:0] dec_sel;

  // Select decode of the incoming request
  pio_decode u_decode (
    .kind_i(req_kind_i),
    .page_i(req_addr_i[15:12]),
    .dma_i(req_dma_i),
    .decode_option_strap_i(decode_option_strap_i),
    .sel_o(dec_sel)
  );

  // Halfword put on the data port for the current phase
  function automatic logic [15:0] write_half(input logic [31:0] wd, input logic up,
                                            input logic wide, input logic mux_n);
    if (wide) begin
      write_half = up ? wd[31:16] : wd[15:0];
    end else begin
      write_half = mux_n ? wd[15:0] : wd[31:16];
    end
  endfunction

  // Read capture; a low hold input freezes the upper halfword
  function automatic logic [31:0] capture(input logic [31:0] old, input logic up,
                                          input logic [15:0] din, input logic hold_n);
    if (up) begin
      capture = hold_n ? {din, old[15:0]} : old;
    end else begin
      capture = {old[31:16], din};
    end
  endfunction

  // ****************
  // Next state
  // ****************
  // Pin controls are derived from the next state so each output is a plain flop
  always_comb begin
    nxt_q = q_ff;
    if (ce_i) begin
      nxt_q.done = 1'b0;
      if (q_ff.ref_cnt == 8'h00) begin
        nxt_q.ref_cnt = pio_pkg::REF_HALF_CYC - 8'h01;
        nxt_q.ref_clk = ~q_ff.ref_clk;
      end else begin
        nxt_q.ref_cnt = q_ff.ref_cnt - 8'h01;
      end
      case (q_ff.st)
        pio_pkg::ST_IDLE: begin
          if (req_i) begin
            nxt_q.st = pio_pkg::ST_SETUP;
            nxt_q.cnt = pio_pkg::SETUP_CYC - 8'h01;
            nxt_q.kind = req_kind_i;
            nxt_q.write = req_write_i;
            nxt_q.wide = req_wide_i;
            nxt_q.dma = req_dma_i && req_kind_i == pio_pkg::KIND_PC;
            nxt_q.last = req_dma_last_i;
            nxt_q.rom_we = rom_write_enable_i;
            nxt_q.up = req_wide_i;
            nxt_q.sel = dec_sel;
            nxt_q.wdata = req_wdata_i;
            nxt_q.bnw = byte_not_word_i;
            nxt_q.dout = write_half(req_wdata_i, req_wide_i, req_wide_i,
                                    xip_halfword_select_n_i);
          end
        end
        pio_pkg::ST_SETUP: begin
          if (q_ff.cnt != 8'h00) begin
            nxt_q.cnt = q_ff.cnt - 8'h01;
          end else if (q_ff.kind == pio_pkg::KIND_MODULE) begin
            nxt_q.st = pio_pkg::ST_HSHAKE;
          end else begin
            nxt_q.st = pio_pkg::ST_STROBE;
            nxt_q.cnt = pio_pkg::STROBE_CYC - 8'h01;
          end
        end
        pio_pkg::ST_HSHAKE: begin
          // Wait for grant; writes finish on it, reads go on to latch-in
          if (!module_io_grant_n_i) begin
            nxt_q.st = q_ff.write ? pio_pkg::ST_HOLD : pio_pkg::ST_LATCH;
          end
        end
        pio_pkg::ST_LATCH: begin
          if (!read_latch_in_n_i) begin
            nxt_q.rdata = capture(q_ff.rdata, q_ff.up, io_data_port_i,
                                  xip_upper_hold_n_i);
            nxt_q.st = pio_pkg::ST_HOLD;
          end
        end
        pio_pkg::ST_STROBE: begin
          if (q_ff.cnt != 8'h00) begin
            nxt_q.cnt = q_ff.cnt - 8'h01;
          end else if (q_ff.kind != pio_pkg::KIND_PC || ready_i) begin
            if (!q_ff.write) begin
              nxt_q.rdata = capture(q_ff.rdata, q_ff.up, io_data_port_i,
                                    xip_upper_hold_n_i);
            end
            nxt_q.st = pio_pkg::ST_HOLD;
          end
        end
        pio_pkg::ST_HOLD: begin
          // Upper phase of a wide access is followed by the lower phase
          if (q_ff.up) begin
            nxt_q.up = 1'b0;
            nxt_q.st = pio_pkg::ST_SETUP;
            nxt_q.cnt = pio_pkg::SETUP_CYC - 8'h01;
            nxt_q.dout = write_half(q_ff.wdata, 1'b0, q_ff.wide, xip_halfword_select_n_i);
          end else begin
            nxt_q.st = pio_pkg::ST_IDLE;
            nxt_q.done = 1'b1;
          end
        end
        default: begin
          nxt_q.st = pio_pkg::ST_IDLE;
        end
      endcase
      // Pin controls for the state being entered
      nxt_q.oe_n = !(nxt_q.st != pio_pkg::ST_IDLE && nxt_q.write);
      nxt_q.rnw = !(nxt_q.st != pio_pkg::ST_IDLE && nxt_q.write);
      nxt_q.rd_n = !(nxt_q.st == pio_pkg::ST_STROBE && !nxt_q.write &&
                     nxt_q.kind != pio_pkg::KIND_MODULE);
      nxt_q.wr_n = !(nxt_q.st == pio_pkg::ST_STROBE && nxt_q.write && !nxt_q.up &&
                     (nxt_q.kind != pio_pkg::KIND_ROM || nxt_q.rom_we));
      nxt_q.blo_n = !(nxt_q.st == pio_pkg::ST_STROBE && nxt_q.write && nxt_q.up);
      nxt_q.rbe_n = !(nxt_q.st != pio_pkg::ST_IDLE && !nxt_q.write &&
                      nxt_q.wide && nxt_q.up);
      nxt_q.wbe_n = !(nxt_q.st != pio_pkg::ST_IDLE && nxt_q.write &&
                      nxt_q.wide && !nxt_q.up);
      nxt_q.rq_n = !(nxt_q.st == pio_pkg::ST_HSHAKE || nxt_q.st == pio_pkg::ST_LATCH);
      // Selects only while a cycle runs; pseudo-DMA uses the acknowledge instead
      nxt_q.cs_n = (nxt_q.st != pio_pkg::ST_IDLE && !nxt_q.dma) ? ~nxt_q.sel : '1;
      nxt_q.cdack_n = !(nxt_q.st != pio_pkg::ST_IDLE && nxt_q.dma);
      nxt_q.tc = nxt_q.st == pio_pkg::ST_STROBE && nxt_q.dma && nxt_q.last &&
                 !nxt_q.up;
    end
  end

  // ****************
  // State register
  // ****************
  // Reset parks every active-low control high so the bus is quiet
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q_ff <= '0;
      q_ff.oe_n <= 1'b1;
      q_ff.rnw <= 1'b1;
      q_ff.rd_n <= 1'b1;
      q_ff.wr_n <= 1'b1;
      q_ff.blo_n <= 1'b1;
      q_ff.rbe_n <= 1'b1;
      q_ff.wbe_n <= 1'b1;
      q_ff.rq_n <= 1'b1;
      q_ff.cs_n <= '1;
      q_ff.cdack_n <= 1'b1;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // Outputs straight from the state flops
  assign busy_o = q_ff.st != pio_pkg::ST_IDLE;
  assign done_o = q_ff.done;
  assign rdata_o = q_ff.rdata;
  assign io_data_port_o = q_ff.dout;
  assign io_data_port_oe_n_o = q_ff.oe_n;
  assign module_io_request_n_o = q_ff.rq_n;
  assign upper_latch_out_n_o = q_ff.blo_n;
  assign upper_read_enable_n_o = q_ff.rbe_n;
  assign upper_write_enable_n_o = q_ff.wbe_n;
  assign io_read_n_o = q_ff.rd_n;
  assign io_write_n_o = q_ff.wr_n;
  assign io_read_not_write_o = q_ff.rnw;
  assign byte_not_word_o = q_ff.bnw;
  assign ref16_clk_o = q_ff.ref_clk;
  assign simple_select_a_n_o = q_ff.cs_n[pio_pkg::SEL_SIMPLE_A];
  assign simple_select_b_n_o = q_ff.cs_n[pio_pkg::SEL_SIMPLE_B];
  assign module_select_n_o = q_ff.cs_n[pio_pkg::SEL_MODULE];
  assign extended_pc_select_n_o = q_ff.cs_n[pio_pkg::SEL_EXT_PC];
  assign combo_select_n_o = q_ff.cs_n[pio_pkg::SEL_COMBO];
  assign combo_dma_ack_n_o = q_ff.cdack_n;
  assign terminal_count_o = q_ff.tc;
  assign pc_area0_select_n_o = q_ff.cs_n[pio_pkg::SEL_AREA0];
  assign pc_area1_select_n_o = q_ff.cs_n[pio_pkg::SEL_AREA1];

  // ****************
  // Assertions
  // ****************
  pc_wait_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (q_ff.st == pio_pkg::ST_STROBE && q_ff.kind == pio_pkg::KIND_PC &&
     q_ff.cnt == 8'h00 && !ready_i && ce_i) |=> (q_ff.st == pio_pkg::ST_STROBE && !io_read_n_o
     || q_ff.write))
    else $error("PC cycle ended while wait input low");
  module_grant_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (q_ff.st == pio_pkg::ST_HSHAKE && module_io_grant_n_i && ce_i) |=>
    (q_ff.st == pio_pkg::ST_HSHAKE && !module_io_request_n_o))
    else $error("Module cycle advanced without grant");
  latch_capture_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (q_ff.st == pio_pkg::ST_LATCH && !read_latch_in_n_i && !q_ff.up && ce_i) |=>
    (rdata_o[15:0] == $past(io_data_port_i) && q_ff.st == pio_pkg::ST_HOLD))
    else $error("Module read data not captured on latch-in");
  upper_latch_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !upper_latch_out_n_o |-> (q_ff.write && q_ff.wide && q_ff.up && io_write_n_o))
    else $error("Upper latch strobe outside wide write upper phase");
  upper_read_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (busy_o && !q_ff.write && q_ff.wide && q_ff.up) |-> !upper_read_enable_n_o)
    else $error("Upper read enable missing in wide read");
  upper_write_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !upper_write_enable_n_o |-> (q_ff.write && q_ff.wide && !q_ff.up && !io_data_port_oe_n_o))
    else $error("Upper write enable outside wide write");
  direction_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    busy_o |-> (io_read_not_write_o == !q_ff.write))
    else $error("Direction output disagrees with cycle");
  module_no_read_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !io_read_n_o |-> (q_ff.kind != pio_pkg::KIND_MODULE && !q_ff.write))
    else $error("Read strobe during module or write cycle");
  rom_write_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (!io_write_n_o && q_ff.kind == pio_pkg::KIND_ROM) |-> q_ff.rom_we)
    else $error("ROM write strobe while ROM writes disabled");
  idle_quiet_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !busy_o |-> (q_ff.cs_n == '1 && combo_dma_ack_n_o && io_read_n_o && io_write_n_o))
    else $error("Select or strobe active while idle");
  ref_toggle_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (q_ff.ref_cnt == 8'h00 && ce_i) |=> (ref16_clk_o != $past(ref16_clk_o)))
    else $error("Reference clock missed its toggle");

endmodule // pio_ctrl

// >>> pio_periph_model.sv
// Model of the peripheral chips on the far side of the I/O bus
`timescale 1ns/1ps
module pio_periph_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Behaviour chosen by the bench
  input wire logic [7:0] wait_cyc_i,
  input wire logic [7:0] grant_cyc_i,
  input wire logic [15:0] rd_hi_i,
  input wire logic [15:0] rd_lo_i,
  // Bus driven by the controller
  input wire logic io_read_n_i,
  input wire logic io_write_n_i,
  input wire logic module_io_request_n_i,
  input wire logic upper_latch_out_n_i,
  input wire logic upper_read_enable_n_i,
  input wire logic io_read_not_write_i,
  input wire logic [15:0] io_data_port_i,
  // Answers to the controller
  output logic ready_o,
  output logic module_io_grant_n_o,
  output logic read_latch_in_n_o,
  output logic [15:0] io_data_port_o,
  output logic [15:0] cap_hi_o,
  output logic [15:0] cap_lo_o
);
  logic [7:0] cnt;
  logic [15:0] last;
  logic [15:0] val;
  logic drive;
  logic open;

  // A released bus shows the inverse so stale data cannot match
  assign open = !io_read_n_i || !io_write_n_i || !module_io_request_n_i;
  assign drive = !io_read_n_i || (!module_io_request_n_i && io_read_not_write_i);
  assign val = !upper_read_enable_n_i ? rd_hi_i : rd_lo_i;
  assign io_data_port_o = drive ? val : ~last;

  // Wait and grant come a set count of cycles after the cycle opens
  assign ready_o = !(!io_read_n_i || !io_write_n_i) || (cnt >= wait_cyc_i);
  assign module_io_grant_n_o = !(!module_io_request_n_i && cnt >= grant_cyc_i);
  assign read_latch_in_n_o = !(!module_io_request_n_i && io_read_not_write_i
                               && cnt >= grant_cyc_i);

  // Cycle counter and write data capture on the strobe
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt <= 8'h00;
      last <= 16'h0000;
      cap_hi_o <= 16'h0000;
      cap_lo_o <= 16'h0000;
    end else begin
      cnt <= !open ? 8'h00 : ((cnt == 8'hFF) ? cnt : cnt + 8'h01);
      if (drive) begin
        last <= val;
      end
      if (!upper_latch_out_n_i) begin
        cap_hi_o <= io_data_port_i;
      end else if (!io_write_n_i) begin
        cap_lo_o <= io_data_port_i;
      end
    end
  end
endmodule // pio_periph_model

// >>> pio_ctrl_bench.sv
// Self-checking bench for the peripheral I/O bus cycle controller
`timescale 1ns/1ps
module pio_ctrl_bench;
  // ****************
  // Signals and instances
  // ****************
  logic clk_i, resetn_i, req_i, req_write_i, req_wide_i, req_dma_i, req_dma_last_i;
  logic byte_not_word_i, rom_write_enable_i, decode_option_strap_i, busy_o, done_o;
  logic xip_halfword_select_n_i, xip_upper_hold_n_i, io_data_port_oe_n_o, ready_i;
  logic module_io_grant_n_i, read_latch_in_n_i, module_io_request_n_o, upper_latch_out_n_o;
  logic upper_read_enable_n_o, upper_write_enable_n_o, io_read_n_o, io_write_n_o;
  logic io_read_not_write_o, byte_not_word_o, ref16_clk_o, simple_select_a_n_o;
  logic simple_select_b_n_o, module_select_n_o, extended_pc_select_n_o, combo_select_n_o;
  logic combo_dma_ack_n_o, terminal_count_o, pc_area0_select_n_o, pc_area1_select_n_o;
  logic ce_i = 1'b1;
  logic [1:0] req_kind_i;
  logic [15:0] req_addr_i, io_data_port_i, io_data_port_o, rd_hi, rd_lo, cap_hi, cap_lo;
  logic [31:0] req_wdata_i, rdata_o;
  logic [7:0] wait_cyc, grant_cyc;
  logic [16:0] act, seen;
  int failures, compares, cnt;

  pio_ctrl DUT (.clk_i, .resetn_i, .ce_i, .req_i, .req_kind_i, .req_write_i, .req_wide_i,
    .req_addr_i, .req_wdata_i, .req_dma_i, .req_dma_last_i, .byte_not_word_i,
    .rom_write_enable_i, .busy_o, .done_o, .rdata_o, .io_data_port_i, .io_data_port_o,
    .io_data_port_oe_n_o, .ready_i, .module_io_grant_n_i, .read_latch_in_n_i,
    .xip_halfword_select_n_i, .xip_upper_hold_n_i, .decode_option_strap_i,
    .module_io_request_n_o, .upper_latch_out_n_o, .upper_read_enable_n_o,
    .upper_write_enable_n_o, .io_read_n_o, .io_write_n_o, .io_read_not_write_o,
    .byte_not_word_o, .ref16_clk_o, .simple_select_a_n_o, .simple_select_b_n_o,
    .module_select_n_o, .extended_pc_select_n_o, .combo_select_n_o, .combo_dma_ack_n_o,
    .terminal_count_o, .pc_area0_select_n_o, .pc_area1_select_n_o);

  pio_periph_model periph (.clk_i(clk_i), .resetn_i(resetn_i), .wait_cyc_i(wait_cyc),
    .grant_cyc_i(grant_cyc), .rd_hi_i(rd_hi), .rd_lo_i(rd_lo), .io_read_n_i(io_read_n_o),
    .io_write_n_i(io_write_n_o), .module_io_request_n_i(module_io_request_n_o),
    .upper_latch_out_n_i(upper_latch_out_n_o), .upper_read_enable_n_i(upper_read_enable_n_o),
    .io_read_not_write_i(io_read_not_write_o), .io_data_port_i(io_data_port_o),
    .ready_o(ready_i), .module_io_grant_n_o(module_io_grant_n_i),
    .read_latch_in_n_o(read_latch_in_n_i), .io_data_port_o(io_data_port_i),
    .cap_hi_o(cap_hi), .cap_lo_o(cap_lo));

  // Active-high activity, read strobe at bit 16
  assign act = {~io_read_n_o, ~io_write_n_o, ~module_io_request_n_o, ~upper_latch_out_n_o,
    ~upper_read_enable_n_o, ~upper_write_enable_n_o, ~simple_select_a_n_o,
    ~simple_select_b_n_o, ~module_select_n_o, ~extended_pc_select_n_o, ~combo_select_n_o,
    ~combo_dma_ack_n_o, ~pc_area0_select_n_o, ~pc_area1_select_n_o, terminal_count_o,
    ~io_read_not_write_o, ~io_data_port_oe_n_o};

  // ****************
  // Shared tasks
  // ****************
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // One access; cnt = edges from take to done
  task automatic access(input logic [1:0] kind, input logic wr, input logic wide,
                        input logic [15:0] addr, input logic [31:0] wdata, input logic dma);
    @(negedge clk_i);
    req_kind_i = kind;
    req_write_i = wr;
    req_wide_i = wide;
    req_addr_i = addr;
    req_wdata_i = wdata;
    req_dma_i = dma;
    seen = '0;
    req_i = 1'b1;
    @(negedge clk_i);
    req_i = 1'b0;
    cnt = 0;
    do begin
      @(negedge clk_i);
      cnt++;
    end while (done_o !== 1'b1 && cnt < 4000);
  endtask

  // Gather activity; nothing may be active while idle
  always @(negedge clk_i) begin
    if (busy_o === 1'b1) begin
      seen <= seen | act;
    end else if (done_o === 1'b0 && resetn_i === 1'b1) begin
      check(act, 17'h00000, "idle activity");
    end
  end

  // ****************
  // Scenarios
  // ****************
  task automatic t_simple();
    byte_not_word_i = 1'b1;
    rd_lo = 16'hA5C3;
    access(pio_pkg::KIND_SIMPLE, 1'b0, 1'b0, 16'h0000, 32'h0, 1'b0);
    check(seen, 17'h10400, "simple read activity");
    check(cnt, 38, "rd len");
    check(rdata_o[15:0], 16'hA5C3, "simple read data");
    check(byte_not_word_o, 1'b1, "size copy");
    byte_not_word_i = 1'b0;
    access(pio_pkg::KIND_SIMPLE, 1'b1, 1'b0, 16'h8000, 32'h12345678, 1'b0);
    check(seen, 17'h08203, "simple write activity");
    check(cap_lo, 16'h5678, "lower halfword");
    check(byte_not_word_o, 1'b0, "size copy");
    xip_halfword_select_n_i = 1'b0;
    access(pio_pkg::KIND_SIMPLE, 1'b1, 1'b0, 16'h8000, 32'h12345678, 1'b0);
    check(cap_lo, 16'h1234, "upper halfword");
    xip_halfword_select_n_i = 1'b1;
    $display("test simple done");
  endtask

  task automatic t_pc();
    logic [16:0] exp_t [6] = '{17'h10040, 17'h10010, 17'h10008, 17'h10080, 17'h10200, 17'h10080};
    logic [15:0] adr_t [6] = '{16'h3000, 16'h4000, 16'h5000, 16'h0000, 16'h0000, 16'h8000};
    for (int i = 0; i < 6; i++) begin
      decode_option_strap_i = (i > 3);
      access(pio_pkg::KIND_PC, 1'b0, 1'b0, adr_t[i], 32'h0, 1'b0);
      check(seen, exp_t[i], "pc select");
      check(cnt, 38, "pc len");
    end
    decode_option_strap_i = 1'b0;
    wait_cyc = 8'd40;
    access(pio_pkg::KIND_PC, 1'b0, 1'b0, 16'h4000, 32'h0, 1'b0);
    check(cnt > 38, 1'b1, "pc wait");
    wait_cyc = 8'd0;
    $display("test pc done");
  endtask

  task automatic t_module();
    int first;
    grant_cyc = 8'd3;
    access(pio_pkg::KIND_MODULE, 1'b1, 1'b0, 16'h0000, 32'h0, 1'b0);
    first = cnt;
    check(seen & 17'h17FFF, 17'h04103, "module write activity");
    grant_cyc = 8'd20;
    access(pio_pkg::KIND_MODULE, 1'b1, 1'b0, 16'h0000, 32'h0, 1'b0);
    check(cnt - first, 17, "grant delay");
    grant_cyc = 8'd5;
    rd_lo = 16'h3C96;
    decode_option_strap_i = 1'b1;
    access(pio_pkg::KIND_MODULE, 1'b0, 1'b0, 16'h8000, 32'h0, 1'b0);
    check(seen, 17'h04080, "module read activity");
    check(rdata_o[15:0], 16'h3C96, "module read data");
    decode_option_strap_i = 1'b0;
    $display("test module done");
  endtask

  task automatic t_wide();
    access(pio_pkg::KIND_SIMPLE, 1'b1, 1'b1, 16'h0000, 32'hCAFE0F1E, 1'b0);
    check(seen, 17'h0AC03, "wide write activity");
    check({cap_hi, cap_lo}, 32'hCAFE0F1E, "wide write data");
    rd_hi = 16'h1357;
    rd_lo = 16'h2468;
    access(pio_pkg::KIND_SIMPLE, 1'b0, 1'b1, 16'h0000, 32'h0, 1'b0);
    check(seen, 17'h11400, "wide read activity");
    check(rdata_o, 32'h13572468, "wide read data");
    xip_upper_hold_n_i = 1'b0;
    rd_hi = 16'hFFFF;
    rd_lo = 16'h0001;
    access(pio_pkg::KIND_SIMPLE, 1'b0, 1'b1, 16'h0000, 32'h0, 1'b0);
    check(rdata_o, 32'h13570001, "upper held");
    xip_upper_hold_n_i = 1'b1;
    $display("test wide done");
  endtask

  task automatic t_dma_rom();
    int n;
    logic prev;
    req_dma_last_i = 1'b1;
    access(pio_pkg::KIND_PC, 1'b1, 1'b0, 16'h0000, 32'h0, 1'b1);
    check(seen, 17'h08027, "last dma transfer");
    req_dma_last_i = 1'b0;
    access(pio_pkg::KIND_PC, 1'b1, 1'b0, 16'h0000, 32'h0, 1'b1);
    check(seen, 17'h08023, "dma transfer");
    access(pio_pkg::KIND_ROM, 1'b1, 1'b0, 16'h0000, 32'h0, 1'b0);
    check(seen, 17'h00003, "rom write refused");
    rom_write_enable_i = 1'b1;
    access(pio_pkg::KIND_ROM, 1'b1, 1'b0, 16'h0000, 32'h0, 1'b0);
    check(seen, 17'h08003, "rom write");
    access(pio_pkg::KIND_ROM, 1'b0, 1'b0, 16'h0000, 32'h0, 1'b0);
    check(seen, 17'h10000, "rom read");
    // Measure a whole reference half period
    prev = ref16_clk_o;
    for (n = 0; n < 20 && ref16_clk_o === prev; n++) @(negedge clk_i);
    prev = ref16_clk_o;
    for (n = 0; n < 20 && ref16_clk_o === prev; n++) @(negedge clk_i);
    check(n, 7, "reference half period");
    $display("test dma, rom and clock done");
  endtask

  // ****************
  // Clock, reset, sequence and watchdog
  // ****************
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  initial begin
    {resetn_i, req_i, req_write_i, req_wide_i, req_dma_i, req_dma_last_i} = '0;
    {byte_not_word_i, rom_write_enable_i, decode_option_strap_i} = '0;
    {xip_halfword_select_n_i, xip_upper_hold_n_i} = 2'h3;
    {req_kind_i, req_addr_i, req_wdata_i, rd_hi, rd_lo, wait_cyc, grant_cyc} = '0;
    repeat (6) @(negedge clk_i);
    check(act, 17'h00000, "activity in reset");
    check({busy_o, done_o, ref16_clk_o}, 3'h0, "reset flags");
    check(rdata_o, 32'h0, "reset rdata");
    resetn_i = 1'b1;
    $display("test reset done");
    t_simple();
    t_pc();
    t_module();
    t_wide();
    t_dma_rom();
    report_and_stop();
  end

  // Run is about a thousand cycles; this is far beyond
  initial begin
    #200000;
    failures++;
    report_and_stop();
  end
endmodule // pio_ctrl_bench
